// ### rtl/utlaf_pkg.sv
package utlaf_pkg;

    // Register addresses: separate read and write addresses per register
    localparam logic [7:0] TX_ALERT_WR_ADDR   = 8'h12;
    localparam logic [7:0] TX_ALERT_RD_ADDR   = 8'h13;
    localparam logic [7:0] SM_ALERT_WR_ADDR   = 8'h14;
    localparam logic [7:0] SM_ALERT_RD_ADDR   = 8'h15;

    // Transmit alert field positions
    localparam int unsigned TRANSMIT_HELD_CONDITION_BIT       = 7;
    localparam int unsigned TX_RSVD_BIT       = 6;
    localparam int unsigned TX_BUSY_BIT       = 5;
    localparam int unsigned TX_IDLE_BIT       = 4;
    localparam int unsigned TX_OVERFLOW_BIT   = 3;
    localparam int unsigned TX_FULL_BIT       = 2;
    localparam int unsigned TX_AVAIL_BIT      = 1;
    localparam int unsigned TX_EMPTY_BIT      = 0;

    // Safety monitor alert field positions
    localparam int unsigned SM_RX_READY_BIT   = 7;
    localparam int unsigned SM_AP_STATUS_BIT  = 6;
    localparam int unsigned SM_COMM_ERR_BIT   = 5;

    // Reset values
    localparam logic [7:0] TX_ALERT_RESET     = 8'h00;
    localparam logic [7:0] SM_ALERT_RESET     = 8'h00;
    localparam logic [7:0] RDATA_RESET        = 8'h00;

    // Bits implemented by this block; the others read as zero
    localparam logic [7:0] TX_ALERT_IMPL      = 8'hBF;
    localparam logic [7:0] SM_ALERT_IMPL      = 8'hE0;

    // Default queue count and message length width
    localparam int unsigned TX_QUEUES_DEF     = 4;
    localparam int unsigned LEN_W_DEF         = 8;

    typedef struct packed {
        logic held;
        logic rsvd;
        logic busy;
        logic idle;
        logic overflow;
        logic full;
        logic avail;
        logic empty;
    } utlaf_tx_alert_t;

    typedef struct packed {
        logic       rx_ready;
        logic       ap_status_err;
        logic       comm_err;
        logic [4:0] other;
    } utlaf_sm_alert_t;

    typedef struct packed {
        logic       wr_en;
        logic       rd_en;
        logic [7:0] addr;
        logic [7:0] wdata;
    } utlaf_reg_req_t;

endpackage : utlaf_pkg

// ### rtl/utlaf_flag_bank.sv
`timescale 1ns/1ps
module utlaf_flag_bank #(
    parameter int unsigned W        = 8,
    parameter logic [W-1:0] IMPL    = '1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         clock_i,
    input  wire logic         rst_n_i,
    input  wire logic [W-1:0] set_i,
    input  wire logic         wr_i,
    input  wire logic [W-1:0] wdata_i,
    input  wire logic [W-1:0] hw_clr_i,
    output logic      [W-1:0] flags_o
);

    typedef struct packed {
        logic [W-1:0] flags;
    } utlaf_fb_state_t;

    utlaf_fb_state_t st_q;
    utlaf_fb_state_t st_d;

    always_comb begin
        st_d = st_q;
        // Writing zero clears, writing one keeps; a set in the same cycle wins
        if (wr_i) begin
            st_d.flags = st_d.flags & wdata_i; // RL11
        end
        st_d.flags = st_d.flags & ~hw_clr_i;
        st_d.flags = (st_d.flags | set_i) & IMPL; // RL20
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            st_q.flags <= RST_VAL;
        end else begin
            st_q <= st_d;
        end
    end

    assign flags_o = st_q.flags;

endmodule : utlaf_flag_bank

// ### rtl/utlaf_queue_ptr.sv
`timescale 1ns/1ps
module utlaf_queue_ptr #(
    parameter int unsigned NQ = utlaf_pkg::TX_QUEUES_DEF,
    parameter int unsigned PW = (NQ > 1) ? $clog2(NQ) : 1
) (
    input  wire logic          clock_i,
    input  wire logic          rst_n_i,
    input  wire logic          load_done_i,
    input  wire logic          sent_i,
    output logic      [PW-1:0] ld_ptr_o,
    output logic      [PW-1:0] tx_ptr_o,
    output logic               empty_o,
    output logic               full_o,
    output logic               overflow_o
);

    if (NQ < 2 || (NQ & (NQ - 1)) != 0) begin : g_check
        $error("utlaf_queue_ptr: NQ must be a power of two, at least 2");
    end

    typedef struct packed {
        logic [PW-1:0] ld;
        logic [PW-1:0] tx;
        logic          ovf;
    } utlaf_qp_state_t;

    utlaf_qp_state_t st_q;
    utlaf_qp_state_t st_d;

    logic [PW-1:0] ld_next;

    always_comb begin
        ld_next = st_q.ld + PW'(1);
        st_d     = st_q;
        st_d.ovf = 1'b0;
        if (sent_i && (st_q.tx != st_q.ld)) begin
            st_d.tx = st_q.tx + PW'(1);
        end
        if (load_done_i) begin
            // Next queue still holds unsent data: stay and overwrite the load queue
            if (ld_next == st_q.tx) begin
                st_d.ovf = 1'b1; // RL7
            end else begin
                st_d.ld = ld_next;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign ld_ptr_o   = st_q.ld;
    assign tx_ptr_o   = st_q.tx;
    assign empty_o    = (st_q.ld == st_q.tx); // RL10
    assign full_o     = (st_q.ld == PW'(st_q.tx - PW'(1))); // RL8
    assign overflow_o = st_q.ovf;

endmodule : utlaf_queue_ptr

// ### rtl/utlaf_top.sv
`timescale 1ns/1ps
// Notes on behaviour
// (RL1) Held flag: free receive bytes below message length
// (RL2) Held and limited: withhold the load queue
// (RL3) Unlimited setting: never held, always transmit
// (RL4) Host should watch receive overflow when unlimited
// (RL5) Busy flag while transmitter sends
// (RL6) Idle flag while transmitter does not send
// (RL7) Overflow flag when load pointer cannot advance
// (RL8) Full flag when load equals transmit minus one
// (RL9) Available flag whenever not full
// (RL10) Empty flag when load equals transmit pointer
// (RL11) Write zero clears, write one keeps
// (RL12) Receive ready on framed message completion
// (RL13) Receive ready clears once all messages read
// (RL14) No receive ready for stop on empty buffer
// (RL15) No receive ready for automatic alert packets
// (RL16) Status error on unmasked alert packet status
// (RL17) Command mode masks with error-mask registers
// (RL18) Sleep/safe masks by debounce masks, auto-clears
// (RL19) Communication error on corrupt, inserted, omitted data
// (RL20) Transmit bit 6 reads zero, ignores writes
module utlaf_top #(
    parameter int unsigned NQ    = utlaf_pkg::TX_QUEUES_DEF,
    parameter int unsigned LEN_W = utlaf_pkg::LEN_W_DEF,
    parameter int unsigned AP_W  = 8,
    parameter int unsigned PW    = (NQ > 1) ? $clog2(NQ) : 1
) (
    input  wire logic                     clock_i,
    input  wire logic                     rst_n_i,
    // Register access at the documented read and write addresses
    input  wire utlaf_pkg::utlaf_reg_req_t reg_req_i,
    output logic                     [7:0] reg_rdata_o,
    output logic                           reg_rvalid_o,
    // Transmit side
    input  wire logic                      unlimited_transmit_setting_i,
    input  wire logic          [LEN_W-1:0] rx_free_bytes_i,
    input  wire logic          [LEN_W-1:0] tx_msg_len_i,
    input  wire logic                      load_done_i,
    input  wire logic                      tx_active_i,
    input  wire logic                      tx_queue_sent_i,
    output logic                           tx_release_o,
    output logic                  [PW-1:0] load_queue_pointer_o,
    output logic                  [PW-1:0] transmit_queue_pointer_o,
    // Receive and safety monitor side
    input  wire logic                      rx_frame_end_i,
    input  wire logic                      rx_buf_empty_i,
    input  wire logic                      alert_packet_transaction_i,
    input  wire logic                      rx_all_read_i,
    input  wire logic                      commanded_mode_i,
    input  wire logic                      ap_status_valid_i,
    input  wire logic           [AP_W-1:0] ap_status_i,
    input  wire logic           [AP_W-1:0] error_mask_i,
    input  wire logic           [AP_W-1:0] debounce_mask_registers_i,
    input  wire logic                      ap_status_debounced_i,
    input  wire logic                      comm_fault_i,
    output logic                     [7:0] transmit_alert_flags_o,
    output logic                     [7:0] safety_monitor_alert_byte_o
);

    if (LEN_W < 1 || AP_W < 1) begin : g_check
        $error("utlaf_top: LEN_W and AP_W must be at least 1");
    end

    // Edge memory of the transmit conditions, release and read data
    typedef struct packed {
        utlaf_pkg::utlaf_tx_alert_t cond_prev;
        logic                       release_q;
        logic [7:0]                 rdata;
        logic                       rvalid;
    } utlaf_top_state_t;

    utlaf_top_state_t st_q;
    utlaf_top_state_t st_d;

    logic [PW-1:0] ld_ptr;
    logic [PW-1:0] tx_ptr;
    logic          q_empty;
    logic          q_full;
    logic          q_overflow;
    logic          held_cond;
    logic          pending;

    utlaf_pkg::utlaf_tx_alert_t cond;
    utlaf_pkg::utlaf_tx_alert_t tx_set;
    utlaf_pkg::utlaf_sm_alert_t sm_set;
    utlaf_pkg::utlaf_sm_alert_t sm_hwclr;
    logic [7:0]                 tx_flags;
    logic [7:0]                 sm_flags;
    logic [AP_W-1:0]            ap_mask;
    logic                       wr_tx;
    logic                       wr_sm;

    function automatic logic rising(input logic now, input logic prev);
        rising = now & ~prev;
    endfunction : rising

    utlaf_queue_ptr #(
        .NQ (NQ),
        .PW (PW)
    ) u_qptr (
        .clock_i     (clock_i),
        .rst_n_i     (rst_n_i),
        .load_done_i (load_done_i),
        .sent_i      (tx_queue_sent_i),
        .ld_ptr_o    (ld_ptr),
        .tx_ptr_o    (tx_ptr),
        .empty_o     (q_empty),
        .full_o      (q_full),
        .overflow_o  (q_overflow)
    );

    assign pending = ~q_empty;

    // Held only when a queue waits, space is short and the limit applies
    always_comb begin
        held_cond = 1'b0;
        if (!unlimited_transmit_setting_i && pending) begin // RL3
            held_cond = (rx_free_bytes_i < tx_msg_len_i); // RL1
        end
    end

    // Transmit conditions laid out as the register
    always_comb begin
        cond          = '0;
        cond.held     = held_cond; // RL1
        cond.busy     = tx_active_i; // RL5
        cond.idle     = ~tx_active_i; // RL6
        cond.full     = q_full; // RL8
        cond.avail    = ~q_full; // RL9
        cond.empty    = q_empty; // RL10
    end

    // Flags are event driven: set on the rising edge of each condition, overflow directly on each queue overflow pulse
    always_comb begin
        tx_set          = '0;
        tx_set.held     = rising(cond.held, st_q.cond_prev.held);
        tx_set.busy     = rising(cond.busy, st_q.cond_prev.busy);
        tx_set.idle     = rising(cond.idle, st_q.cond_prev.idle);
        tx_set.overflow = q_overflow; // RL7
        tx_set.full     = rising(cond.full, st_q.cond_prev.full);
        tx_set.avail    = rising(cond.avail, st_q.cond_prev.avail);
        tx_set.empty    = rising(cond.empty, st_q.cond_prev.empty);
    end

    // Receive-ready and alert-packet status evaluation
    always_comb begin
        ap_mask = commanded_mode_i ? error_mask_i : debounce_mask_registers_i; // RL17 RL18
        sm_set  = '0;
        sm_set.rx_ready = rx_frame_end_i & ~rx_buf_empty_i // RL12 RL14
                        & ~alert_packet_transaction_i; // RL15
        sm_set.ap_status_err = ap_status_valid_i & (|(ap_status_i & ~ap_mask)); // RL16
        sm_set.comm_err      = comm_fault_i; // RL19
        sm_hwclr = '0;
        sm_hwclr.rx_ready      = rx_all_read_i; // RL13
        sm_hwclr.ap_status_err = ~commanded_mode_i & ap_status_debounced_i; // RL18
    end

    assign wr_tx = reg_req_i.wr_en && (reg_req_i.addr == utlaf_pkg::TX_ALERT_WR_ADDR);
    assign wr_sm = reg_req_i.wr_en && (reg_req_i.addr == utlaf_pkg::SM_ALERT_WR_ADDR);

    utlaf_flag_bank #(
        .W       (8),
        .IMPL    (utlaf_pkg::TX_ALERT_IMPL),
        .RST_VAL (utlaf_pkg::TX_ALERT_RESET)
    ) u_tx_flags (
        .clock_i  (clock_i),
        .rst_n_i  (rst_n_i),
        .set_i    (tx_set),
        .wr_i     (wr_tx),
        .wdata_i  (reg_req_i.wdata),
        .hw_clr_i (8'h00),
        .flags_o  (tx_flags)
    );

    utlaf_flag_bank #(
        .W       (8),
        .IMPL    (utlaf_pkg::SM_ALERT_IMPL),
        .RST_VAL (utlaf_pkg::SM_ALERT_RESET)
    ) u_sm_flags (
        .clock_i  (clock_i),
        .rst_n_i  (rst_n_i),
        .set_i    (sm_set),
        .wr_i     (wr_sm),
        .wdata_i  (reg_req_i.wdata),
        .hw_clr_i (sm_hwclr),
        .flags_o  (sm_flags)
    );

    always_comb begin
        st_d           = st_q;
        st_d.cond_prev = cond;
        // Release the head queue only when not held
        st_d.release_q = pending & ~held_cond; // RL2 RL3
        st_d.rvalid    = reg_req_i.rd_en;
        if (reg_req_i.rd_en) begin
            case (reg_req_i.addr)
                utlaf_pkg::TX_ALERT_RD_ADDR: begin
                    st_d.rdata = tx_flags;
                end
                utlaf_pkg::SM_ALERT_RD_ADDR: begin
                    st_d.rdata = sm_flags;
                end
                default: begin
                    st_d.rdata = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            st_q.cond_prev <= '0;
            st_q.release_q <= 1'b0;
            st_q.rdata     <= utlaf_pkg::RDATA_RESET;
            st_q.rvalid    <= 1'b0;
        end else begin
            st_q <= st_d;
        end
    end

    assign reg_rdata_o                 = st_q.rdata;
    assign reg_rvalid_o                = st_q.rvalid;
    assign tx_release_o                = st_q.release_q;
    assign load_queue_pointer_o        = ld_ptr;
    assign transmit_queue_pointer_o    = tx_ptr;
    assign transmit_alert_flags_o      = tx_flags;
    assign safety_monitor_alert_byte_o = sm_flags;

endmodule : utlaf_top

// ### dv/utlaf_top_sva.sv
`timescale 1ns/1ps
module utlaf_top_sva #(
    parameter int unsigned LEN_W = 8,
    parameter int unsigned AP_W  = 8
) (
    input wire logic                      clock_i,
    input wire logic                      rst_n_i,
    input wire utlaf_pkg::utlaf_reg_req_t reg_req_i,
    input wire logic                      unlimited_transmit_setting_i,
    input wire logic [LEN_W-1:0]          rx_free_bytes_i,
    input wire logic [LEN_W-1:0]          tx_msg_len_i,
    input wire logic                      tx_release_o,
    input wire logic                      rx_frame_end_i,
    input wire logic                      rx_buf_empty_i,
    input wire logic                      alert_packet_transaction_i,
    input wire logic                      rx_all_read_i,
    input wire logic                      commanded_mode_i,
    input wire logic                      ap_status_valid_i,
    input wire logic [AP_W-1:0]           ap_status_i,
    input wire logic [AP_W-1:0]           error_mask_i,
    input wire logic [AP_W-1:0]           debounce_mask_registers_i,
    input wire logic                      comm_fault_i,
    input wire logic [7:0]                transmit_alert_flags_o,
    input wire logic [7:0]                safety_monitor_alert_byte_o
);
    logic            ready_cause;
    logic            ap_hit;
    logic [AP_W-1:0] ap_mask;

    assign ready_cause = rx_frame_end_i && !rx_buf_empty_i && !alert_packet_transaction_i;
    assign ap_mask     = commanded_mode_i ? error_mask_i : debounce_mask_registers_i;
    assign ap_hit      = ap_status_valid_i && ((ap_status_i & ~ap_mask) != '0);

    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    keep_one_a: assert property (reg_req_i.wr_en && reg_req_i.addr == utlaf_pkg::TX_ALERT_WR_ADDR &&
        reg_req_i.wdata == 8'hFF |=> ($past(transmit_alert_flags_o) & ~transmit_alert_flags_o) == 8'h00)
        else $error("write of ones cleared a flag");
    comm_clear_a: assert property (reg_req_i.wr_en && reg_req_i.addr == utlaf_pkg::SM_ALERT_WR_ADDR &&
        !reg_req_i.wdata[5] && !comm_fault_i |=> !safety_monitor_alert_byte_o[5])
        else $error("write of zero kept comm flag");
    ready_set_a: assert property (ready_cause |=> safety_monitor_alert_byte_o[7])
        else $error("receive ready not set");
    ready_cause_a: assert property ($rose(safety_monitor_alert_byte_o[7]) |-> $past(ready_cause))
        else $error("receive ready set without cause");
    all_read_a: assert property (rx_all_read_i && !ready_cause |=> !safety_monitor_alert_byte_o[7])
        else $error("receive ready not cleared");
    ap_set_a: assert property (ap_hit |=> safety_monitor_alert_byte_o[6])
        else $error("status error not set");
    ap_cause_a: assert property ($rose(safety_monitor_alert_byte_o[6]) |-> $past(ap_hit))
        else $error("status error set while masked");
    comm_set_a: assert property (comm_fault_i |=> safety_monitor_alert_byte_o[5])
        else $error("comm flag not set");
    unl_held_a: assert property (unlimited_transmit_setting_i [*4] |-> !$rose(transmit_alert_flags_o[7]))
        else $error("held flag set while unlimited");
    hold_tx_a: assert property ((!unlimited_transmit_setting_i && rx_free_bytes_i < tx_msg_len_i) [*4]
        |-> !tx_release_o)
        else $error("released while held");
endmodule : utlaf_top_sva

bind utlaf_top utlaf_top_sva #(.LEN_W(LEN_W), .AP_W(AP_W)) i_sva (.*);

// ### dv/utlaf_tx_model.sv
`timescale 1ns/1ps
module utlaf_tx_model (
    input  wire logic clock_i,
    input  wire logic rst_n_i,
    input  wire logic release_i,
    input  wire logic slow_i,
    output logic      active_o,
    output logic      sent_o
);
    logic [7:0] cnt_q;

    // One queue per release, then two idle cycles so the registered release can drop
    always @(negedge clock_i) begin
        if (!rst_n_i) begin
            cnt_q <= 8'h00;
        end else if (cnt_q != 8'h00) begin
            cnt_q <= cnt_q - 8'h01;
        end else if (release_i) begin
            cnt_q <= slow_i ? 8'h12 : 8'h06;
        end
    end

    assign active_o = cnt_q > 8'h02;
    assign sent_o   = cnt_q == 8'h03;
endmodule : utlaf_tx_model

// ### dv/test_uart_tx_and_lock_step_safety_monitor_alert_flags.sv
`timescale 1ns/1ps
module test_uart_tx_and_lock_step_safety_monitor_alert_flags;
    localparam logic [7:0] tx_rd = utlaf_pkg::TX_ALERT_RD_ADDR;
    localparam logic [7:0] tx_wr = utlaf_pkg::TX_ALERT_WR_ADDR;
    localparam logic [7:0] sm_rd = utlaf_pkg::SM_ALERT_RD_ADDR;
    localparam logic [7:0] sm_wr = utlaf_pkg::SM_ALERT_WR_ADDR;
    utlaf_pkg::utlaf_reg_req_t reg_req_i;
    logic clock_i, rst_n_i, unlimited_transmit_setting_i, load_done_i, tx_active_i, tx_queue_sent_i, tx_slow;
    logic rx_frame_end_i, rx_buf_empty_i, alert_packet_transaction_i, rx_all_read_i, commanded_mode_i;
    logic ap_status_valid_i, ap_status_debounced_i, comm_fault_i, reg_rvalid_o, tx_release_o;
    logic [7:0] rx_free_bytes_i, tx_msg_len_i, ap_status_i, error_mask_i, debounce_mask_registers_i;
    logic [7:0] reg_rdata_o, transmit_alert_flags_o, safety_monitor_alert_byte_o;
    logic [1:0] load_queue_pointer_o, transmit_queue_pointer_o;
    int mismatches, n_checks;

    utlaf_top i_dut (.*);
    utlaf_tx_model i_tx (.clock_i(clock_i), .rst_n_i(rst_n_i), .release_i(tx_release_o), .slow_i(tx_slow),
        .active_o(tx_active_i), .sent_o(tx_queue_sent_i));

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : wrap_up

    task automatic tick(input int n);
        repeat (n) @(negedge clock_i);
    endtask : tick

    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        reg_req_i.rd_en = 1'b1;
        reg_req_i.addr = a;
        tick(1);
        reg_req_i.rd_en = 1'b0;
        chk("read valid", {7'h00, reg_rvalid_o}, 8'h01);
        chk($sformatf("register %h", a), reg_rdata_o, exp);
        // Let an edge pass so a following read never re-raises the strobe in this time step
        tick(1);
    endtask : rd

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_req_i.wr_en = 1'b1;
        reg_req_i.addr = a;
        reg_req_i.wdata = d;
        tick(1);
        reg_req_i.wr_en = 1'b0;
        tick(1);
    endtask : wr

    task automatic load();
        load_done_i = 1'b1;
        tick(1);
        load_done_i = 1'b0;
        tick(3);
    endtask : load

    // Bit k of the one-cycle safety events, then read back the alert byte
    task automatic ev(input int k, input logic [7:0] exp);
        {ap_status_debounced_i, ap_status_valid_i, comm_fault_i, rx_all_read_i, rx_frame_end_i} = 5'h01 << k;
        tick(1);
        {ap_status_debounced_i, ap_status_valid_i, comm_fault_i, rx_all_read_i, rx_frame_end_i} = 5'h00;
        tick(1);
        rd(sm_rd, exp);
    endtask : ev

    task automatic wait_drain();
        int i;
        for (i = 0; i < 300; i++) begin
            if (load_queue_pointer_o === transmit_queue_pointer_o && tx_active_i === 1'b0) break;
            tick(1);
        end
        if (i == 300) begin
            mismatches++;
            wrap_up();
        end
        tick(4);
    endtask : wait_drain

    task automatic sc_regs();
        rd(tx_rd, 8'h13);
        wr(tx_wr, 8'hFF);
        rd(tx_rd, 8'h13);
        wr(tx_wr, 8'hEE);
        rd(tx_rd, 8'h02);
        wr(8'h20, 8'h00);
        rd(tx_rd, 8'h02);
        rd(8'h20, 8'h00);
        wr(tx_wr, 8'h40);
        rd(tx_rd, 8'h00);
    endtask : sc_regs

    task automatic sc_fill();
        rx_free_bytes_i = 8'h02;
        repeat (4) load();
        chk("release", {7'h00, tx_release_o}, 8'h00);
        chk("load pointer", {6'h00, load_queue_pointer_o}, 8'h03);
        rd(tx_rd, 8'h8C);
    endtask : sc_fill

    task automatic sc_drain();
        wr(tx_wr, 8'h00);
        tx_slow = 1'b1;
        rx_free_bytes_i = 8'hFF;
        wait_drain();
        chk("tx pointer", {6'h00, transmit_queue_pointer_o}, 8'h03);
        rd(tx_rd, 8'h33);
    endtask : sc_drain

    task automatic sc_unlimited();
        unlimited_transmit_setting_i = 1'b1;
        tx_slow = 1'b0;
        rx_free_bytes_i = 8'h02;
        wr(tx_wr, 8'h00);
        load();
        wait_drain();
        rd(tx_rd, 8'h31);
    endtask : sc_unlimited

    task automatic sc_safety();
        wr(sm_wr, 8'h00);
        rx_buf_empty_i = 1'b1;
        ev(0, 8'h00);
        rx_buf_empty_i = 1'b0;
        alert_packet_transaction_i = 1'b1;
        ev(0, 8'h00);
        alert_packet_transaction_i = 1'b0;
        ev(0, 8'h80);
        ev(1, 8'h00);
        ev(2, 8'h20);
        commanded_mode_i = 1'b1;
        error_mask_i = 8'h01;
        ap_status_i = 8'h01;
        ev(3, 8'h20);
        ap_status_i = 8'h03;
        ev(3, 8'h60);
        wr(sm_wr, 8'hBF);
        rd(sm_rd, 8'h20);
        commanded_mode_i = 1'b0;
        error_mask_i = 8'hFF;
        debounce_mask_registers_i = 8'h02;
        ap_status_i = 8'h02;
        ev(3, 8'h20);
        ap_status_i = 8'h04;
        ev(3, 8'h60);
        ev(4, 8'h20);
    endtask : sc_safety

    initial begin
        clock_i = 1'b0;
        forever #20 clock_i = ~clock_i;
    end

    initial begin
        reg_req_i = '0;
        rst_n_i = 1'b0;
        {unlimited_transmit_setting_i, load_done_i, tx_slow, rx_frame_end_i, rx_buf_empty_i} = 5'h00;
        {alert_packet_transaction_i, rx_all_read_i, commanded_mode_i, comm_fault_i} = 4'h0;
        {ap_status_valid_i, ap_status_debounced_i} = 2'h0;
        {ap_status_i, error_mask_i, debounce_mask_registers_i} = 24'h000000;
        rx_free_bytes_i = 8'hFF;
        tx_msg_len_i = 8'h04;
        tick(10);
        chk("tx flags in reset", transmit_alert_flags_o, 8'h00);
        chk("sm byte in reset", safety_monitor_alert_byte_o, 8'h00);
        rst_n_i = 1'b1;
        tick(4);
        sc_regs();
        sc_fill();
        sc_drain();
        sc_unlimited();
        sc_safety();
        wrap_up();
    end
endmodule : test_uart_tx_and_lock_step_safety_monitor_alert_flags
